// ==== verilog/rmcg_pkg.sv ====
// Package for the run-mode peripheral clock gate bank 1.
// Assumes one 40 MHz system clock and an APB register slave.
package rmcg_pkg;
	localparam int RMCG_DATA_W = 32;
	localparam int RMCG_ADDR_W = 12;
	localparam int RMCG_UNITS = 7;
	// Register byte offsets
	localparam logic [11:0] RMCG_RUN_GATE_OFS = 12'h104;
	localparam logic [11:0] RMCG_SLEEP_GATE_OFS = 12'h114;
	localparam logic [11:0] RMCG_DEEP_GATE_OFS = 12'h124;
	localparam logic [11:0] RMCG_CLK_CFG_OFS = 12'h060;
	localparam logic [31:0] RMCG_SYSCTL_BASE = 32'h400f_e000;
	// Field positions
	localparam int RMCG_CMP_ZERO_BIT = 24;
	localparam int RMCG_TMR2_BIT = 18;
	localparam int RMCG_TMR1_BIT = 17;
	localparam int RMCG_TMR0_BIT = 16;
	localparam int RMCG_SYNC_ZERO_BIT = 4;
	localparam int RMCG_ASYNC_ONE_BIT = 1;
	localparam int RMCG_ASYNC_ZERO_BIT = 0;
	localparam int RMCG_AUTO_SEL_BIT = 27;
	// Writable bits and reset values
	localparam logic [31:0] RMCG_GATE_MASK = 32'h0107_0013;
	localparam logic [31:0] RMCG_CFG_MASK = 32'h0800_0000;
	localparam logic [31:0] RMCG_GATE_RESET = 32'h0000_0000;
	localparam logic [31:0] RMCG_CFG_RESET = 32'h0000_0000;
	// Power mode encoding
	typedef enum logic [1:0] {
		RMCG_MODE_RUN = 2'b00,
		RMCG_MODE_SLEEP = 2'b01,
		RMCG_MODE_DEEP = 2'b10
	} rmcg_mode_e;
endpackage

// ==== verilog/rmcg_gate_reg.sv ====
// One gating register: writable bits only, others read as zero.
// Assumes the caller decodes the write strobe.
`timescale 1ns/100ps
`default_nettype none
module rmcg_gate_reg
	import rmcg_pkg::*;
#(
	parameter logic [31:0] MASK = RMCG_GATE_MASK,
	parameter logic [31:0] RESET_VAL = RMCG_GATE_RESET
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	output logic [31:0] value
);
	logic [31:0] value_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			value_r <= RESET_VAL;
		end else if (wr_en) begin
			value_r <= wr_data & MASK;
		end
	end

	assign value = value_r;
endmodule
`default_nettype wire

// ==== verilog/rmcg_unit_gate.sv ====
// Per-unit clock enable and bus fault qualifier.
// Assumes the unit's clock gate cell is outside and takes the enable.
`timescale 1ns/100ps
`default_nettype none
module rmcg_unit_gate (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic gate_on,
	input wire logic unit_psel,
	output logic clk_en,
	output logic fault
);
	logic clk_en_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			clk_en_r <= 1'b0;
		end else begin
			clk_en_r <= gate_on;
		end
	end

	assign clk_en = clk_en_r;
	// Access to an unclocked unit faults
	assign fault = unit_psel & ~clk_en_r;
endmodule
`default_nettype wire

// ==== verilog/rmcg_bank1.sv ====
// Run-mode clock gate bank 1 with sleep and deep-sleep companions.
// Assumes an APB master on core_clk and a power controller giving the mode.
//
// Overview of operation
// R01: A set gating bit clocks its unit, a clear bit leaves it unclocked and disabled.
// R02: An access to a unit whose gate is clear answers with a bus fault.
// R03: Every gating bit resets to zero so all units start unclocked.
// R04: Bit 24 gates analog comparator zero.
// R05: Bits 18, 17 and 16 gate timers two, one and zero.
// R06: Bit 4 gates synchronous serial port zero.
// R07: Bits 1 and 0 gate serial ports one and zero.
// R08: Unused bits are read-only and read as zero.
// R09: Software preserves unused bits on read-modify-write and ignores them.
// R10: The run register applies in run mode, twin registers hold sleep and deep-sleep gates.
// R11: Sleep registers apply only when automatic clock gating is set.
// R12: The run register sits at offset 0x104 and is 32 bits wide.
// R13: With automatic gating clear, the run gates stay in force during sleep.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rmcg_bank1
	import rmcg_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RMCG_ADDR_W-1:0] paddr,
	input wire logic [RMCG_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [RMCG_DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic [1:0] power_mode,
	input wire logic [RMCG_UNITS-1:0] unit_psel,
	output logic [RMCG_UNITS-1:0] unit_clk_en,
	output logic [RMCG_UNITS-1:0] unit_fault
);
	// Slot of each unit on the per-unit ports
	localparam int SLOT_CMP_ZERO = 6;
	localparam int SLOT_CNT_TWO = 5;
	localparam int SLOT_CNT_ONE = 4;
	localparam int SLOT_CNT_ZERO = 3;
	localparam int SLOT_SYNC_ZERO = 2;
	localparam int SLOT_ASYNC_ONE = 1;
	localparam int SLOT_ASYNC_ZERO = 0;

	logic [31:0] run_gate;
	logic [31:0] sleep_gate;
	logic [31:0] deep_gate;
	logic [31:0] clk_cfg;
	logic [31:0] wdata_m;
	logic [31:0] cur_reg;
	logic [31:0] active_gate;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic wr_phase;
	logic hit_run;
	logic hit_sleep;
	logic hit_deep;
	logic hit_cfg;
	logic hit_any;
	logic auto_clock_gating_select;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_cfg;
	logic comparator_zero_gate;
	logic gp_counter_two_gate;
	logic gp_counter_one_gate;
	logic gp_counter_zero_gate;
	logic sync_serial_zero_gate;
	logic async_serial_one_gate;
	logic async_serial_zero_gate;

	// Single-cycle access phase, no wait states
	assign pready = 1'b1;
	assign wr_phase = psel & penable & pwrite;

	// R12: run register offset
	assign hit_run = (paddr == RMCG_RUN_GATE_OFS);
	assign hit_sleep = (paddr == RMCG_SLEEP_GATE_OFS);
	assign hit_deep = (paddr == RMCG_DEEP_GATE_OFS);
	assign hit_cfg = (paddr == RMCG_CLK_CFG_OFS);
	assign hit_any = hit_run | hit_sleep | hit_deep | hit_cfg;

	// Write strobes, one per register
	assign wr_run = wr_phase & hit_run;
	assign wr_sleep = wr_phase & hit_sleep;
	assign wr_deep = wr_phase & hit_deep;
	assign wr_cfg = wr_phase & hit_cfg;

	// Register selected by the address, zero when nothing matches
	always_comb begin
		cur_reg = 32'h0000_0000;
		if (hit_run) begin
			cur_reg = run_gate;
		end else if (hit_sleep) begin
			cur_reg = sleep_gate;
		end else if (hit_deep) begin
			cur_reg = deep_gate;
		end else if (hit_cfg) begin
			cur_reg = clk_cfg;
		end
	end

	// Byte lanes merge write data with the held value
	always_comb begin
		wdata_m = cur_reg;
		for (int b = 0; b < 4; b++) begin
			wdata_m[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : cur_reg[b*8 +: 8];
		end
	end

	// R03: gates reset to zero; R08: unused bits masked
	rmcg_gate_reg #(
		.MASK(RMCG_GATE_MASK),
		.RESET_VAL(RMCG_GATE_RESET)
	) u_run_gate (
		.core_clk(core_clk),
		.reset(reset),
		.wr_en(wr_run),
		.wr_data(wdata_m),
		.value(run_gate)
	);

	// R10: sleep twin register
	rmcg_gate_reg #(
		.MASK(RMCG_GATE_MASK),
		.RESET_VAL(RMCG_GATE_RESET)
	) u_sleep_gate (
		.core_clk(core_clk),
		.reset(reset),
		.wr_en(wr_sleep),
		.wr_data(wdata_m),
		.value(sleep_gate)
	);

	// R10: deep-sleep twin register
	rmcg_gate_reg #(
		.MASK(RMCG_GATE_MASK),
		.RESET_VAL(RMCG_GATE_RESET)
	) u_deep_gate (
		.core_clk(core_clk),
		.reset(reset),
		.wr_en(wr_deep),
		.wr_data(wdata_m),
		.value(deep_gate)
	);

	// Clock configuration holding the automatic gating select
	rmcg_gate_reg #(
		.MASK(RMCG_CFG_MASK),
		.RESET_VAL(RMCG_CFG_RESET)
	) u_clk_cfg (
		.core_clk(core_clk),
		.reset(reset),
		.wr_en(wr_cfg),
		.wr_data(wdata_m),
		.value(clk_cfg)
	);

	assign auto_clock_gating_select = clk_cfg[RMCG_AUTO_SEL_BIT];

	// R11: sleep gates need automatic gating; R13: else run gates stay
	always_comb begin
		active_gate = run_gate;
		case (power_mode)
			RMCG_MODE_RUN: begin
				active_gate = run_gate;
			end
			RMCG_MODE_SLEEP: begin
				active_gate = auto_clock_gating_select ? sleep_gate : run_gate;
			end
			RMCG_MODE_DEEP: begin
				active_gate = auto_clock_gating_select ? deep_gate : run_gate;
			end
			default: begin
				active_gate = run_gate;
			end
		endcase
	end

	// R04: comparator zero
	assign comparator_zero_gate = active_gate[RMCG_CMP_ZERO_BIT];
	// R05: timers two, one, zero
	assign gp_counter_two_gate = active_gate[RMCG_TMR2_BIT];
	assign gp_counter_one_gate = active_gate[RMCG_TMR1_BIT];
	assign gp_counter_zero_gate = active_gate[RMCG_TMR0_BIT];
	// R06: synchronous serial zero
	assign sync_serial_zero_gate = active_gate[RMCG_SYNC_ZERO_BIT];
	// R07: serial ports one and zero
	assign async_serial_one_gate = active_gate[RMCG_ASYNC_ONE_BIT];
	assign async_serial_zero_gate = active_gate[RMCG_ASYNC_ZERO_BIT];

	// R01 R02: comparator zero enable
	rmcg_unit_gate u_cmp_zero_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(comparator_zero_gate),
		.unit_psel(unit_psel[SLOT_CMP_ZERO]),
		.clk_en(unit_clk_en[SLOT_CMP_ZERO]),
		.fault(unit_fault[SLOT_CMP_ZERO])
	);

	// R01 R02: timer two enable
	rmcg_unit_gate u_cnt_two_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(gp_counter_two_gate),
		.unit_psel(unit_psel[SLOT_CNT_TWO]),
		.clk_en(unit_clk_en[SLOT_CNT_TWO]),
		.fault(unit_fault[SLOT_CNT_TWO])
	);

	// R01 R02: timer one enable
	rmcg_unit_gate u_cnt_one_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(gp_counter_one_gate),
		.unit_psel(unit_psel[SLOT_CNT_ONE]),
		.clk_en(unit_clk_en[SLOT_CNT_ONE]),
		.fault(unit_fault[SLOT_CNT_ONE])
	);

	// R01 R02: timer zero enable
	rmcg_unit_gate u_cnt_zero_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(gp_counter_zero_gate),
		.unit_psel(unit_psel[SLOT_CNT_ZERO]),
		.clk_en(unit_clk_en[SLOT_CNT_ZERO]),
		.fault(unit_fault[SLOT_CNT_ZERO])
	);

	// R01 R02: synchronous serial enable
	rmcg_unit_gate u_sync_zero_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(sync_serial_zero_gate),
		.unit_psel(unit_psel[SLOT_SYNC_ZERO]),
		.clk_en(unit_clk_en[SLOT_SYNC_ZERO]),
		.fault(unit_fault[SLOT_SYNC_ZERO])
	);

	// R01 R02: serial one enable
	rmcg_unit_gate u_async_one_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(async_serial_one_gate),
		.unit_psel(unit_psel[SLOT_ASYNC_ONE]),
		.clk_en(unit_clk_en[SLOT_ASYNC_ONE]),
		.fault(unit_fault[SLOT_ASYNC_ONE])
	);

	// R01 R02: serial zero enable
	rmcg_unit_gate u_async_zero_gate (
		.core_clk(core_clk),
		.reset(reset),
		.gate_on(async_serial_zero_gate),
		.unit_psel(unit_psel[SLOT_ASYNC_ZERO]),
		.clk_en(unit_clk_en[SLOT_ASYNC_ZERO]),
		.fault(unit_fault[SLOT_ASYNC_ZERO])
	);

	// Read data registered at setup, valid in the access phase
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel & ~penable) begin
			prdata_nxt = 32'h0000_0000;
			if (~pwrite) begin
				prdata_nxt = cur_reg;
			end
		end
	end

	// Unmapped address answers with an error in the access phase
	always_comb begin
		pslverr_nxt = 1'b0;
		if (psel & ~penable) begin
			pslverr_nxt = ~hit_any;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r & psel & penable;
endmodule
`default_nettype wire

// ==== dv/rmcg_bank1_chk.sv ====
// Port checker for rmcg_bank1.
// Assumes APB traffic on core_clk; bound to the design below.
`timescale 1ns/100ps
`default_nettype none
module rmcg_bank1_chk
	import rmcg_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [1:0] power_mode,
	input wire logic [6:0] unit_psel,
	input wire logic [6:0] unit_clk_en,
	input wire logic [6:0] unit_fault
);
	logic auto_sel_r;
	logic acc, wr, hit;
	logic [6:0] map_w;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign hit = paddr inside {12'h104, 12'h114, 12'h124, 12'h060};
	assign map_w = {pwdata[24], pwdata[18:16], pwdata[4], pwdata[1:0]};
	// Mirror of the automatic gating select
	always_ff @(posedge core_clk) begin
		if (reset)
			auto_sel_r <= 1'b0;
		else if (wr && paddr == 12'h060 && pstrb[3])
			auto_sel_r <= pwdata[27];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_fault_from_gate: assert property (unit_fault == (unit_psel & ~unit_clk_en))
		else $error("unit fault differs from gate state");
	a_reset_all_off: assert property ($fell(reset) |-> unit_clk_en == 7'h00 && !pslverr)
		else $error("units clocked after reset");
	a_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && hit |-> pready && !pslverr)
		else $error("mapped access refused");
	a_unused_zero: assert property (acc && !pwrite && paddr inside {12'h104, 12'h114, 12'h124}
		|-> (prdata & ~RMCG_GATE_MASK) == 32'h0)
		else $error("unused bits read nonzero");
	a_cfg_readback: assert property (acc && !pwrite && paddr == 12'h060
		|-> prdata == (auto_sel_r ? RMCG_CFG_MASK : 32'h0))
		else $error("config readback wrong");
	a_run_gate_map: assert property (wr && paddr == 12'h104 && pstrb == 4'hf ##1 power_mode == 2'b00
		|=> unit_clk_en == $past(map_w, 2))
		else $error("run gate bits not applied");
	a_auto_off_hold: assert property (!auto_sel_r && !wr ##1 !wr |=> $stable(unit_clk_en))
		else $error("enables moved without gate write");
endmodule
bind rmcg_bank1 rmcg_bank1_chk u_rmcg_bank1_chk (.core_clk(core_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .power_mode(power_mode),
	.unit_psel(unit_psel), .unit_clk_en(unit_clk_en), .unit_fault(unit_fault));
`default_nettype wire

// ==== dv/rmcg_bank1_bench.sv ====
// Self-checking bench for rmcg_bank1 over APB.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
`default_nettype none
module rmcg_bank1_bench;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] power_mode = 2'b00;
	logic [6:0] unit_psel = 7'h7f, unit_clk_en, unit_fault;
	int failures = 0, samples_checked = 0;
	int pos[7] = '{0, 1, 4, 16, 17, 18, 24};
	rmcg_bank1 u_rmcg_bank1 (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .power_mode(power_mode), .unit_psel(unit_psel),
		.unit_clk_en(unit_clk_en), .unit_fault(unit_fault));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task t_bits;
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, 12'h104, 32'h1 << pos[i], 4'hf);
			@(posedge core_clk);
			chk(unit_clk_en, 7'h1 << i);
			chk(unit_fault, 7'h7f ^ (7'h1 << i));
			xfer(1'b0, 12'h104, 32'h0, 4'hf);
			chk(rd, 32'h1 << pos[i]);
		end
		unit_psel <= 7'h41;
		@(posedge core_clk);
		chk(unit_fault, 7'h01);
		unit_psel <= 7'h7f;
	endtask
	task t_unused;
		xfer(1'b1, 12'h104, 32'hffff_ffff, 4'hf);
		xfer(1'b0, 12'h104, 32'h0, 4'hf);
		chk(rd, 32'h0107_0013);
		xfer(1'b1, 12'h104, rd & ~32'h1, 4'hf);
		xfer(1'b1, 12'h104, 32'h0, 4'h1);
		xfer(1'b0, 12'h104, 32'h0, 4'hf);
		chk(rd, 32'h0107_0000);
		xfer(1'b1, 12'h200, 32'hffff_ffff, 4'hf);
		chk(er, 1'b1);
		xfer(1'b0, 12'h200, 32'h0, 4'hf);
		chk(er, 1'b1);
		chk(rd, 32'h0);
	endtask
	task t_modes;
		xfer(1'b1, 12'h114, 32'h1, 4'hf);
		xfer(1'b1, 12'h124, 32'h10, 4'hf);
		xfer(1'b1, 12'h104, 32'h0107_0013, 4'hf);
		power_mode <= 2'b01;
		repeat (2) @(posedge core_clk);
		chk(unit_clk_en, 7'h7f);
		xfer(1'b1, 12'h060, 32'h0800_0000, 4'hf);
		xfer(1'b0, 12'h060, 32'h0, 4'hf);
		chk(rd, 32'h0800_0000);
		chk(unit_clk_en, 7'h01);
		power_mode <= 2'b10;
		repeat (2) @(posedge core_clk);
		chk(unit_clk_en, 7'h04);
		power_mode <= 2'b11;
		repeat (2) @(posedge core_clk);
		chk(unit_clk_en, 7'h7f);
		power_mode <= 2'b00;
		repeat (2) @(posedge core_clk);
		chk(unit_clk_en, 7'h7f);
	endtask
	task t_reset;
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		chk(unit_clk_en, 7'h00);
		xfer(1'b0, 12'h060, 32'h0, 4'hf);
		chk(rd, 32'h0);
		xfer(1'b0, 12'h104, 32'h0, 4'hf);
		chk(rd, 32'h0);
		chk(unit_fault, 7'h7f);
	endtask
	task close_out;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge core_clk);
		failures++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		xfer(1'b0, 12'h104, 32'h0, 4'hf);
		chk(rd, 32'h0);
		chk(unit_fault, 7'h7f);
		t_bits;
		t_unused;
		t_modes;
		t_reset;
		close_out;
	end
endmodule
`default_nettype wire
